// ===== hdl/io_port_pkg.sv
package io_port_pkg;
	// register map, word index on the plain register port
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFF_DIR = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_LATCH = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_PIN = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_ODC = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_ANSEL = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_CNEN = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_PU = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_PD = 4'h7;
	localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_MASK = 4'h9;
	localparam logic [ADDR_W-1:0] OFF_LOCK = 4'hA;
	// lock bit position inside the lock register
	localparam int LOCK_BIT = 6;
	// per-bit reset values
	localparam logic DIR_RST = 1'b1;
	localparam logic ANSEL_RST = 1'b1;
	localparam logic CLR_RST = 1'b0;
endpackage : io_port_pkg

// ===== hdl/io_port_change_notify.sv
`timescale 1ns/100ps
// Operation
// - open-drain bit set makes an output pin pull low only, never drive high
// - analog-select register resets to all ones, pins start analog
// - pin value reads zero on every analog input pin
// - output with analog-select set feeds its level to the analog side
// - change on an enabled digital input pin raises interrupt if unmasked, detected even clockless
// - change-notice enable bit set enables, cleared disables, per pin
// - weak pull-up and pull-down enabled separately, active when set
// - lock bit sits at bit 6 of its register, one means locked
module io_port_change_notify #(
	parameter int WIDTH = io_port_pkg::DATA_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [io_port_pkg::ADDR_W-1:0] addr,
	input wire logic [io_port_pkg::DATA_W-1:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [io_port_pkg::DATA_W-1:0] rdData,
	input wire logic [WIDTH-1:0] padIn,
	output logic [WIDTH-1:0] padOut,
	output logic [WIDTH-1:0] padOe,
	output logic [WIDTH-1:0] pullUpEn,
	output logic [WIDTH-1:0] pullDnEn,
	output logic [WIDTH-1:0] analogEn,
	output logic [WIDTH-1:0] analogDrive,
	output logic configLocked,
	output logic changeWake,
	output logic irq
);
	import io_port_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] dir;
		logic [WIDTH-1:0] latch;
		logic [WIDTH-1:0] odc;
		logic [WIDTH-1:0] ansel;
		logic [WIDTH-1:0] cnen;
		logic [WIDTH-1:0] pu;
		logic [WIDTH-1:0] pd;
		logic [WIDTH-1:0] stat;
		logic [WIDTH-1:0] mask;
		logic lock;
		logic [WIDTH-1:0] sync1;
		logic [WIDTH-1:0] sync2;
		logic [WIDTH-1:0] sync3;
		logic [WIDTH-1:0] stable;
		logic [DATA_W-1:0] rdData;
	} state_t;

	state_t st_ff;
	state_t nxt_st;
	logic [WIDTH-1:0] digIn;
	logic [WIDTH-1:0] watch;
	logic [WIDTH-1:0] events;

	// address match for a write or read strobe
	function automatic logic hit(input logic stb,
		input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = stb && (a == off);
	endfunction : hit

	// register width view of a port-wide vector
	function automatic logic [DATA_W-1:0] widen(input logic [WIDTH-1:0] v);
		widen = DATA_W'(v);
	endfunction : widen

	// pins watched for change: enabled digital inputs
	assign watch = st_ff.cnen & st_ff.dir & ~st_ff.ansel;
	// analog inputs read as zero
	assign digIn = st_ff.stable & ~(st_ff.ansel & st_ff.dir);
	// a filtered level change counts once second and third stages agree
	assign events = (st_ff.stable ^ st_ff.sync3) &
		~(st_ff.sync2 ^ st_ff.sync3) & watch;

	// next state of all registers
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.sync1 = padIn;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.sync3 = st_ff.sync2;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st_ff.sync2[i] == st_ff.sync3[i])
				nxt_st.stable[i] = st_ff.sync3[i];
		end
		if (hit(wrStb, addr, OFF_DIR))
			nxt_st.dir = wrData[WIDTH-1:0];
		if (hit(wrStb, addr, OFF_LATCH) || hit(wrStb, addr, OFF_PIN))
			nxt_st.latch = wrData[WIDTH-1:0];
		if (hit(wrStb, addr, OFF_ODC) && !st_ff.lock)
			nxt_st.odc = wrData[WIDTH-1:0];
		if (hit(wrStb, addr, OFF_ANSEL) && !st_ff.lock)
			nxt_st.ansel = wrData[WIDTH-1:0];
		if (hit(wrStb, addr, OFF_CNEN))
			nxt_st.cnen = wrData[WIDTH-1:0];
		if (hit(wrStb, addr, OFF_PU) && !st_ff.lock)
			nxt_st.pu = wrData[WIDTH-1:0];
		if (hit(wrStb, addr, OFF_PD) && !st_ff.lock)
			nxt_st.pd = wrData[WIDTH-1:0];
		if (hit(wrStb, addr, OFF_MASK))
			nxt_st.mask = wrData[WIDTH-1:0];
		if (hit(wrStb, addr, OFF_LOCK))
			nxt_st.lock = wrData[LOCK_BIT];
		// write one to clear, a new event wins over the clear
		if (hit(wrStb, addr, OFF_STAT))
			nxt_st.stat = st_ff.stat & ~wrData[WIDTH-1:0];
		nxt_st.stat = nxt_st.stat | events;
		// read data stand for one cycle only
		nxt_st.rdData = '0;
		if (rdStb)
		begin
			case (addr)
				OFF_DIR: nxt_st.rdData = widen(st_ff.dir);
				OFF_LATCH: nxt_st.rdData = widen(st_ff.latch);
				OFF_PIN: nxt_st.rdData = widen(digIn);
				OFF_ODC: nxt_st.rdData = widen(st_ff.odc);
				OFF_ANSEL: nxt_st.rdData = widen(st_ff.ansel);
				OFF_CNEN: nxt_st.rdData = widen(st_ff.cnen);
				OFF_PU: nxt_st.rdData = widen(st_ff.pu);
				OFF_PD: nxt_st.rdData = widen(st_ff.pd);
				OFF_STAT: nxt_st.rdData = widen(st_ff.stat);
				OFF_MASK: nxt_st.rdData = widen(st_ff.mask);
				OFF_LOCK: nxt_st.rdData[LOCK_BIT] = st_ff.lock;
				default: nxt_st.rdData = '0;
			endcase
		end
	end

	// state register with synchronous reset
	// reset leaves every pin an undriven analog input, nothing can glitch
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_ff <= '0;
			st_ff.dir <= {WIDTH{DIR_RST}};
			st_ff.ansel <= {WIDTH{ANSEL_RST}};
			st_ff.lock <= CLR_RST;
		end
		else
			st_ff <= nxt_st;
	end

	// pin drive: push-pull or low-only on outputs
	assign padOe = ~st_ff.dir & ~(st_ff.odc & st_ff.latch);
	assign padOut = st_ff.latch & ~st_ff.odc;
	assign pullUpEn = st_ff.pu;
	assign pullDnEn = st_ff.pd;
	assign analogEn = st_ff.ansel;
	assign analogDrive = st_ff.latch & ~st_ff.dir & st_ff.ansel;
	assign configLocked = st_ff.lock;
	assign rdData = st_ff.rdData;
	assign irq = |(st_ff.stat & st_ff.mask);
	// clockless wake: raw pin against last settled level
	assign changeWake = |((padIn ^ st_ff.stable) & watch);

	// assertion helpers
	sequence s_pinRead;
		rdStb && addr == OFF_PIN;
	endsequence

	sequence s_lockWrite;
		wrStb && addr == OFF_LOCK;
	endsequence

	property p_ansel_reset;
		@(posedge clk) !rst_n |=> analogEn == {WIDTH{ANSEL_RST}};
	endproperty
	a_ansel_reset: assert property (p_ansel_reset)
		else $error("analog select not all ones after reset");

	property p_open_drain;
		@(posedge clk) disable iff (!rst_n)
		(padOe & padOut & st_ff.odc) == '0;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("open-drain pin driven high");

	property p_dir_input;
		@(posedge clk) disable iff (!rst_n)
		(padOe & st_ff.dir) == '0 &&
		(padOut & padOe) == (st_ff.latch & ~st_ff.dir & ~st_ff.odc);
	endproperty
	a_dir_input: assert property (p_dir_input)
		else $error("pin drive disagrees with direction");

	property p_pin_read;
		logic [WIDTH-1:0] an;
		@(posedge clk) disable iff (!rst_n)
		(s_pinRead, an = st_ff.ansel & st_ff.dir)
		|=> (rdData[WIDTH-1:0] & an) == '0;
	endproperty
	a_pin_read: assert property (p_pin_read)
		else $error("analog input pin read nonzero");

	property p_change_sets;
		logic [WIDTH-1:0] ev;
		@(posedge clk) disable iff (!rst_n)
		(events != '0, ev = events) |=> (st_ff.stat & ev) == ev;
	endproperty
	a_change_sets: assert property (p_change_sets)
		else $error("enabled change not recorded");

	property p_no_spurious;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (st_ff.stat & ~$past(st_ff.stat) & ~$past(watch)) == '0;
	endproperty
	a_no_spurious: assert property (p_no_spurious)
		else $error("status set on a disabled pin");

	property p_pull_write;
		@(posedge clk) disable iff (!rst_n)
		(wrStb && addr == OFF_PU && !configLocked)
		|=> pullUpEn == $past(wrData[WIDTH-1:0]);
	endproperty
	a_pull_write: assert property (p_pull_write)
		else $error("pull-up enable not taken");

	property p_lock_bit;
		@(posedge clk) disable iff (!rst_n)
		s_lockWrite |=> configLocked == $past(wrData[LOCK_BIT]);
	endproperty
	a_lock_bit: assert property (p_lock_bit)
		else $error("lock bit not taken from bit six");

	property p_analog_drive;
		@(posedge clk) disable iff (!rst_n)
		(wrStb && addr == OFF_DIR && analogEn[0] && !wrData[0])
		|=> analogDrive[0] == st_ff.latch[0] ##1 1'b1;
	endproperty
	a_analog_drive: assert property (p_analog_drive)
		else $error("analog side not fed the output level");

	sequence s_statClear;
		wrStb && addr == OFF_STAT;
	endsequence

	sequence s_dirWrite;
		wrStb && addr == OFF_DIR;
	endsequence

	// a one written to status clears it unless a new event lands
	property p_stat_clear;
		logic [WIDTH-1:0] w;
		@(posedge clk) disable iff (!rst_n)
		(s_statClear, w = wrData[WIDTH-1:0] & ~events)
		|=> (st_ff.stat & w) == '0;
	endproperty
	a_stat_clear: assert property (p_stat_clear)
		else $error("status bit not cleared by a one");

	// an event in the clearing cycle must survive the clear
	property p_event_wins;
		logic [WIDTH-1:0] ev;
		@(posedge clk) disable iff (!rst_n)
		(s_statClear ##0 (events != '0), ev = events)
		|=> (st_ff.stat & ev) == ev;
	endproperty
	a_event_wins: assert property (p_event_wins)
		else $error("event lost against a status clear");

	// locked pin setup ignores writes
	property p_lock_hold;
		@(posedge clk) disable iff (!rst_n)
		(wrStb && configLocked && (addr == OFF_ODC || addr == OFF_ANSEL ||
		addr == OFF_PU || addr == OFF_PD))
		|=> $stable(pullUpEn) && $stable(pullDnEn) && $stable(analogEn) &&
		$stable(st_ff.odc);
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("locked pin setup changed by a write");

	// level interrupt follows unmasked status
	property p_irq_level;
		@(posedge clk) disable iff (!rst_n)
		irq == ((st_ff.stat & st_ff.mask) != '0);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt level disagrees with status");

	// no wake request when no pin is watched
	property p_wake_watch;
		@(posedge clk) disable iff (!rst_n)
		(watch == '0) |-> !changeWake;
	endproperty
	a_wake_watch: assert property (p_wake_watch)
		else $error("wake raised with no pin enabled");

	// pins written as inputs stop driving on the next cycle
	property p_dir_write;
		logic [WIDTH-1:0] d;
		@(posedge clk) disable iff (!rst_n)
		(s_dirWrite, d = wrData[WIDTH-1:0]) |=> (padOe & d) == '0;
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("input pin still driven after direction write");

	// read data stand only in the cycle after a read strobe
	property p_rd_idle;
		@(posedge clk) disable iff (!rst_n)
		!rdStb |=> rdData == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data present without a read");
endmodule : io_port_change_notify

// ===== dv/pin_partner.sv
`timescale 1ns/100ps
// outside circuit: device drive, then a source, then pulls, else resistor
module pin_partner (
	input wire logic [15:0] padOut,
	input wire logic [15:0] padOe,
	input wire logic [15:0] pullUpEn,
	input wire logic [15:0] pullDnEn,
	input wire logic [15:0] extEn,
	input wire logic [15:0] extVal,
	output logic [15:0] padIn
);
	// resolve each pin level
	always_comb
	begin
		for (int i = 0; i < 16; i++)
		begin
			if (padOe[i])
				padIn[i] = padOut[i];
			else if (extEn[i])
				padIn[i] = extVal[i];
			else if (pullDnEn[i] && !pullUpEn[i])
				padIn[i] = 1'b0;
			else
				padIn[i] = 1'b1;
		end
	end
endmodule : pin_partner

// ===== dv/io_port_change_notify_test.sv
`timescale 1ns/100ps
// register port and pin stimulus with self-checking scenarios
module io_port_change_notify_test;
	import io_port_pkg::*;
	logic clk, rst_n, wrStb, rdStb, configLocked, changeWake, irq;
	logic [3:0] addr;
	logic [15:0] wrData, rdData, padIn, padOut, padOe, pullUpEn, pullDnEn;
	logic [15:0] analogEn, analogDrive, extEn, extVal;
	int badCount, numChecks;
	io_port_change_notify #(.WIDTH(16)) i_io_port_change_notify (.clk(clk),
		.rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .padIn(padIn), .padOut(padOut),
		.padOe(padOe), .pullUpEn(pullUpEn), .pullDnEn(pullDnEn),
		.analogEn(analogEn), .analogDrive(analogDrive),
		.configLocked(configLocked), .changeWake(changeWake), .irq(irq));
	pin_partner i_pin_partner (.padOut(padOut), .padOe(padOe),
		.pullUpEn(pullUpEn), .pullDnEn(pullDnEn), .extEn(extEn),
		.extVal(extVal), .padIn(padIn));
	// verdict and end of run
	task automatic closeOut();
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : closeOut
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		numChecks++;
		if (g !== e)
		begin
			badCount++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one-cycle write, then one idle edge
	task automatic wr(logic [3:0] a, logic [15:0] d);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
		@(posedge clk);
	endtask : wr
	// one-cycle read, data judged in the following cycle
	task automatic rd(logic [3:0] a, logic [15:0] e);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		chk("rdData", e, rdData);
		@(posedge clk);
	endtask : rd
	task automatic waitIrq(logic lvl);
		int n;
		n = 0;
		while (irq !== lvl && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		chk("irq", {15'h0000, lvl}, {15'h0000, irq});
		if (n == 20)
			closeOut();
	endtask : waitIrq
	task automatic resetScen();
		chk("analogEn", 16'hFFFF, analogEn);
		chk("padOe", 16'h0000, padOe);
		rd(OFF_ANSEL, 16'hFFFF);
		rd(OFF_DIR, 16'hFFFF);
		rd(4'hF, 16'h0000);
	endtask : resetScen
	task automatic driveScen();
		wr(OFF_ANSEL, 16'h0000);
		wr(OFF_ODC, 16'h000F);
		wr(OFF_LATCH, 16'h0A5A);
		wr(OFF_DIR, 16'hFF00);
		chk("padOut", 16'h0A50, padOut);
		chk("padOe", 16'h00F5, padOe);
		repeat (5) @(posedge clk);
		rd(OFF_PIN, 16'hFF5A);
	endtask : driveScen
	task automatic analogScen();
		extVal <= 16'hFFFF;
		extEn <= 16'hFFF0;
		wr(OFF_DIR, 16'hFFF0);
		wr(OFF_ANSEL, 16'hF00F);
		chk("analogEn", 16'hF00F, analogEn);
		chk("analogDrive", 16'h000A, analogDrive);
		repeat (5) @(posedge clk);
		rd(OFF_PIN, 16'h0FFA);
	endtask : analogScen
	task automatic irqScen();
		extVal <= 16'h0000;
		extEn <= 16'hFFFF;
		wr(OFF_ANSEL, 16'h0000);
		wr(OFF_DIR, 16'hFFFF);
		repeat (6) @(posedge clk);
		wr(OFF_STAT, 16'hFFFF);
		wr(OFF_CNEN, 16'h0008);
		wr(OFF_MASK, 16'h0008);
		extVal <= 16'h0018;
		@(posedge clk);
		chk("changeWake", 16'h0001, {15'h0000, changeWake});
		waitIrq(1'b1);
		rd(OFF_STAT, 16'h0008);
		chk("changeWake", 16'h0000, {15'h0000, changeWake});
		wr(OFF_STAT, 16'h0008);
		waitIrq(1'b0);
		wr(OFF_MASK, 16'h0000);
		extVal <= 16'h0000;
		repeat (8) @(posedge clk);
		chk("irq", 16'h0000, {15'h0000, irq});
		rd(OFF_STAT, 16'h0008);
	endtask : irqScen
	task automatic lockScen();
		wr(OFF_PU, 16'h00A0);
		wr(OFF_PD, 16'h0050);
		chk("pullUpEn", 16'h00A0, pullUpEn);
		chk("pullDnEn", 16'h0050, pullDnEn);
		wr(OFF_LOCK, 16'h0040);
		chk("configLocked", 16'h0001, {15'h0000, configLocked});
		rd(OFF_LOCK, 16'h0040);
		wr(OFF_PU, 16'h0000);
		rd(OFF_PU, 16'h00A0);
	endtask : lockScen
	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// reset, then the scenarios in turn
	initial
	begin
		rst_n = 1'b0;
		wrStb = 1'b0;
		rdStb = 1'b0;
		addr = 4'h0;
		wrData = 16'h0000;
		extEn = 16'h0000;
		extVal = 16'h0000;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		resetScen();
		driveScen();
		analogScen();
		irqScen();
		lockScen();
		closeOut();
	end
endmodule : io_port_change_notify_test
